// ===== pkg/sss_defs.svh
// Constants of the system sleep state sequencer: field layouts, state codes, timing counts.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH

// ****************************************************************
// Control word layout
// ****************************************************************
`define SSS_TYPE_LSB       10
`define SSS_TYPE_W        3
`define SSS_TRIG_BIT      13
`define SSS_CTRL_W        16

// ****************************************************************
// Sleep type codes per state
// ****************************************************************
`define SSS_TYP_S0        3'h0
`define SSS_TYP_S1        3'h1
`define SSS_TYP_S2        3'h2
`define SSS_TYP_S3        3'h3
`define SSS_TYP_S4        3'h4
`define SSS_TYP_S5        3'h5

// ****************************************************************
// Timing: settle time between power steps, in ns, and its cycle count at 4 ns
// ****************************************************************
`define SSS_CLK_NS        4
`define SSS_SETTLE_NS     40
`define SSS_SETTLE_CYC    ((`SSS_SETTLE_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)

// ****************************************************************
// Power resource reference levels and device states
// ****************************************************************
`define SSS_NRES          8
`define SSS_NDEV          4
`define SSS_DSTATE_D3     2'h3

`endif

// ===== pkg/sss_pkg.sv
// Types of the system sleep state sequencer.
// Assumes sss_defs.svh for the numeric constants.
package sss_pkg;

  // ****************************************************************
  // System states
  // ****************************************************************
  typedef enum logic [2:0] {
    SSS_S0 = 3'h0,
    SSS_S1 = 3'h1,
    SSS_S2 = 3'h2,
    SSS_S3 = 3'h3,
    SSS_S4 = 3'h4,
    SSS_S5 = 3'h5
  } sss_state_t;

  // Control write from software: data and strobe for each controller half.
  typedef struct packed {
    logic        wr;    // One-cycle write strobe.
    logic [15:0] data;  // Written control word.
  } sss_ctrl_wr_t;

  // Retention and execution status shown to the platform.
  typedef struct packed {
    logic run;          // Processors may execute.
    logic cpu_keep;     // Processor context retained.
    logic dram_keep;    // DRAM contents retained.
    logic boot_resume;  // Next start goes through the boot location.
    logic full_boot;    // Next start needs a complete boot.
    logic s4_image;     // A saved memory image must be restored.
  } sss_status_t;

endpackage : sss_pkg

// ===== hw/sss_dev_gate.sv
// Device state gate: while sleeping, forces a device to D3 unless every referenced resource is on.
// Assumes per-device reference masks for the requested state from the surroundings.
`timescale 1ns/1ps
`include "sss_defs.svh"

module sss_dev_gate #(
  parameter int NRES = `SSS_NRES
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // Requested device state and its resource needs
  input  wire logic [1:0]      want_dstate,
  input  wire logic [NRES-1:0] need_mask,
  // Present resource power
  input  wire logic [NRES-1:0] res_on,
  input  wire logic            sleeping,
  // Granted device state
  output logic      [1:0]      dstate
);

  // Registered grant: D3 when sleeping and any needed resource is off.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dstate <= `SSS_DSTATE_D3;
    end
    else if (sleeping && ((need_mask & ~res_on) != '0))
    begin
      dstate <= `SSS_DSTATE_D3;
    end
    else
    begin
      dstate <= want_dstate;
    end
  end

endmodule : sss_dev_gate

// ===== hw/sss_top.sv
// System sleep state sequencer: takes sleep type and trigger, drives power and retention.
// Assumes control writes and wake inputs come from logic on the same clock.
//
// Behaviour
// - S0 runs processors, DRAM kept read/write.
// - S1 stops execution, keeps context, S0 resources off.
// - Wake from S1 resumes where execution stopped.
// - S2 loses context, keeps DRAM, S0-S1 resources off.
// - S3 keeps DRAM, S0-S2 resources off.
// - Wake from S2/S3 starts at boot location.
// - Sleeping device only in state with resources on.
// - S4 keeps nothing, all D3, S0-S3 off.
// - Enabled device wake returns system to S0.
// - Firmware hibernate optional, direct S4 always supported.
// - S5 needs full boot, code differs from S4.
`timescale 1ns/1ps
`include "sss_defs.svh"

module sss_top #(
  parameter int NRES   = `SSS_NRES,
  parameter int NDEV   = `SSS_NDEV,
  parameter int SETTLE = `SSS_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Software control writes
  input  wire sss_pkg::sss_ctrl_wr_t primary_pm_control,
  input  wire sss_pkg::sss_ctrl_wr_t secondary_pm_control,
  input  wire logic                  firmware_assisted_hibernate,
  // Power resource levels: lowest system state each resource supplies
  input  wire logic [NRES-1:0][2:0]  res_level,
  // Devices: wanted state, resource needs, wake enable and wake request
  input  wire logic [NDEV-1:0][1:0]  dev_want,
  input  wire logic [NDEV-1:0][NRES-1:0] dev_need,
  input  wire logic [NDEV-1:0]       wake_enable,
  input  wire logic [NDEV-1:0]       wake_request,
  // Outputs to the platform
  output logic [NRES-1:0]            res_on,
  output logic [NDEV-1:0][1:0]       dev_state,
  output sss_pkg::sss_status_t       status,
  output sss_pkg::sss_state_t        sys_state,
  output logic                       busy,
  output logic                       wake_event
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NRES < 1 || NDEV < 1 || SETTLE < 1)
  begin : g_bad
    $error("sss_top: NRES, NDEV and SETTLE must be at least one.");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A resource stays on in a state only if its level is at or above that state.
  function automatic logic [NRES-1:0] res_for(input logic [2:0] st,
                                              input logic [NRES-1:0][2:0] lvl);
    logic [NRES-1:0] m;
    m = '0;
    for (int i = 0; i < NRES; i++)
    begin
      m[i] = (st == `SSS_TYP_S0) ? 1'b1 : (lvl[i] >= st);
    end
    return m;
  endfunction : res_for

  // Legal sleep type codes; S4 needs direct entry, always available.
  function automatic logic type_ok(input logic [2:0] t);
    return t <= `SSS_TYP_S5;
  endfunction : type_ok

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_SLEEP, SEQ_WAKE} sss_seq_t;

  sss_seq_t            seq;         // Sequencer phase.
  logic [2:0]          target;      // Chosen target state code.
  logic [15:0]         settle_cnt;  // Settle countdown.
  logic [2:0]          last_sleep;  // State that the last wake ended.
  logic                trig;        // Trigger seen this cycle.
  logic [2:0]          trig_type;   // Type carried by that write.
  logic                any_wake;    // Enabled wake raised.

  // Trigger on either half, type taken from the triggering write itself.
  always_comb
  begin
    trig      = 1'b0;
    trig_type = `SSS_TYP_S0;
    if (primary_pm_control.wr && primary_pm_control.data[`SSS_TRIG_BIT])
    begin
      trig      = 1'b1;
      trig_type = primary_pm_control.data[`SSS_TYPE_LSB +: `SSS_TYPE_W];
    end
    else if (secondary_pm_control.wr && secondary_pm_control.data[`SSS_TRIG_BIT])
    begin
      trig      = 1'b1;
      trig_type = secondary_pm_control.data[`SSS_TYPE_LSB +: `SSS_TYPE_W];
    end
  end

  // Wake only from devices that are enabled and raising a wake request.
  assign any_wake = |(wake_enable & wake_request);

  // Phase control: settle, sleep, wake back to S0.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      seq        <= SEQ_IDLE;
      target     <= `SSS_TYP_S0;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      unique case (seq)
        SEQ_IDLE:
        begin
          if (trig && type_ok(trig_type) && trig_type != `SSS_TYP_S0)
          begin
            seq        <= SEQ_SETTLE;
            target     <= trig_type;
            settle_cnt <= 16'(SETTLE - 1);
          end
        end
        SEQ_SETTLE:
        begin
          if (settle_cnt == 16'h0000)
          begin
            seq <= SEQ_SLEEP;
          end
          else
          begin
            settle_cnt <= settle_cnt - 16'h0001;
          end
        end
        SEQ_SLEEP:
        begin
          if (any_wake)
          begin
            seq        <= SEQ_WAKE;
            settle_cnt <= 16'(SETTLE - 1);
          end
        end
        SEQ_WAKE:
        begin
          if (settle_cnt == 16'h0000)
          begin
            seq    <= SEQ_IDLE;
            target <= `SSS_TYP_S0;
          end
          else
          begin
            settle_cnt <= settle_cnt - 16'h0001;
          end
        end
      endcase
    end
  end

  // Record which sleep the wake ended, to pick the resume path.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      last_sleep <= `SSS_TYP_S5;
    end
    else if (seq == SEQ_SLEEP && any_wake)
    begin
      last_sleep <= target;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Visible system state follows the sequencer phase.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sys_state <= sss_pkg::SSS_S0;
    end
    else if (seq == SEQ_SLEEP)
    begin
      sys_state <= sss_pkg::sss_state_t'(target);
    end
    else
    begin
      sys_state <= sss_pkg::SSS_S0;
    end
  end

  // Resources switched off by level in the sleeping state.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      res_on <= '1;
    end
    else if (seq == SEQ_SLEEP)
    begin
      res_on <= res_for(target, res_level);
    end
    else
    begin
      res_on <= '1;
    end
  end

  // Retention and resume status per state.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status <= '0;
    end
    else
    begin
      status.run         <= (seq == SEQ_IDLE);
      status.cpu_keep    <= (seq != SEQ_SLEEP) || (target == `SSS_TYP_S1);
      status.dram_keep   <= (seq != SEQ_SLEEP) || (target <= `SSS_TYP_S3);
      status.boot_resume <= (last_sleep != `SSS_TYP_S1);
      status.full_boot   <= (last_sleep == `SSS_TYP_S5);
      status.s4_image    <= (last_sleep == `SSS_TYP_S4) && !firmware_assisted_hibernate;
    end
  end

  // One-cycle wake pulse when the system returns to S0.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_event <= 1'b0;
    end
    else
    begin
      wake_event <= (seq == SEQ_WAKE) && (settle_cnt == 16'h0000);
    end
  end

  // Sequencer busy outside the working idle phase.
  assign busy = (seq != SEQ_IDLE);

  // ****************************************************************
  // Device gates
  // ****************************************************************
  // The gates judge against the resource mask of the state being entered.
  // The registered res_on lags by a cycle, so a device could otherwise keep its state
  // for one cycle after its supply drops.
  // In S4 and S5 the gates count on no resource, and every device needs all of them there, so all go to D3.
  logic [NRES-1:0] gate_res;  // Resources that the device gates may count on.
  assign gate_res = (seq == SEQ_SLEEP && target < `SSS_TYP_S4)
                    ? res_for(target, res_level) : '0;

  for (genvar d = 0; d < NDEV; d++)
  begin : g_dev
    logic [NRES-1:0] need;
    assign need = (seq == SEQ_SLEEP && target >= `SSS_TYP_S4) ? '1 : dev_need[d];
    sss_dev_gate #(
      .NRES        (NRES)
    ) u_gate (
      .clk         (clk),
      .reset       (reset),
      .want_dstate (dev_want[d]),
      .need_mask   (need),
      .res_on      (gate_res),
      .sleeping    (seq == SEQ_SLEEP),
      .dstate      (dev_state[d])
    );
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_TRIG_START: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_IDLE && !trig) |=> (seq == SEQ_IDLE))
    else $error("Sequencer left idle without a trigger.");

  AST_S0_RUN: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_IDLE) |=> status.run && status.dram_keep)
    else $error("Working state not running with DRAM kept.");

  AST_S1_KEEP: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && target == `SSS_TYP_S1) |=> status.cpu_keep && !status.run)
    else $error("S1 lost context or kept running.");

  AST_S2_CTX: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && target == `SSS_TYP_S2) |=> !status.cpu_keep && status.dram_keep)
    else $error("S2 retention wrong.");

  AST_S4_DRAM: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && target == `SSS_TYP_S4) |=> !status.dram_keep)
    else $error("S4 kept DRAM.");

  AST_RES_OFF: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && $past(seq) == SEQ_SLEEP)
      |-> ((res_on & ~res_for(target, res_level)) == '0))
    else $error("Resource left on above its level.");

  AST_WAKE_S0: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && any_wake) |-> ##[1:300] (seq == SEQ_IDLE))
    else $error("Wake did not return to S0.");

  AST_RESUME_S1: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && any_wake && target == `SSS_TYP_S1) |-> ##2 !status.boot_resume)
    else $error("S1 wake went through boot location.");

  AST_RESUME_BOOT: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && any_wake && (target == `SSS_TYP_S2 || target == `SSS_TYP_S3))
      |-> ##2 status.boot_resume)
    else $error("S2/S3 wake did not start at boot location.");

  AST_S5_BOOT: assert property (@(posedge clk) disable iff (reset)
    (seq == SEQ_SLEEP && any_wake && target == `SSS_TYP_S5) |-> ##2 status.full_boot)
    else $error("S5 wake did not demand full boot.");

endmodule : sss_top

// ===== bench/sss_far_side.sv
// Far-side model: power resources, devices and one wake source facing the sequencer.
// Assumes the bench orders each wake through go, dev and delay.
`timescale 1ns/1ps
`include "sss_defs.svh"

module sss_far_side #(
  parameter int NRES = `SSS_NRES,
  parameter int NDEV = `SSS_NDEV
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Wake order from the bench
  input  wire logic                 go,
  input  wire logic [1:0]           dev,
  input  wire logic [3:0]           delay,
  input  wire logic                 wake_event,
  // Platform side seen by the sequencer
  output logic [NRES-1:0][2:0]      res_level,
  output logic [NDEV-1:0][1:0]      dev_want,
  output logic [NDEV-1:0][NRES-1:0] dev_need,
  output logic [NDEV-1:0]           wake_request
);
  // ****************************************************************
  // Fixed platform make-up
  // ****************************************************************
  logic       armed;  // A wake is pending or raised.
  logic [3:0] count;  // Cycles left before the request rises.
  logic [1:0] who;    // Device that will ask for the wake.

  // Resource i stays on down to sleep state i.
  always_comb
  begin
    for (int i = 0; i < NRES; i++)
      res_level[i] = 3'(i);
  end

  // Device 0 needs the deepest resource, device 3 the shallowest.
  assign dev_want = {2'h1, 2'h0, 2'h2, 2'h1};
  assign dev_need = {8'h01, 8'h00, 8'h02, 8'h80};

  // ****************************************************************
  // Wake source
  // ****************************************************************
  // Raise the request after the delay and hold it until the wake shows.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      armed <= 1'b0;
      count <= 4'h0;
      who <= 2'h0;
      wake_request <= '0;
    end
    else if (go && !armed)
    begin
      armed <= 1'b1;
      count <= delay;
      who <= dev;
    end
    else if (armed && count != 4'h0)
      count <= count - 4'h1;
    else if (wake_event)
    begin
      armed <= 1'b0;
      wake_request <= '0;
    end
    else if (armed)
      wake_request[who] <= 1'b1;
  end
endmodule : sss_far_side

// ===== bench/sss_top_bench.sv
// Self-checking bench of the sleep state sequencer with a far-side model.
// Assumes the default settle count and a 4 ns clock.
`timescale 1ns/1ps
`include "sss_defs.svh"

module sss_top_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                  clk = 1'b0;    // System clock.
  logic                  reset = 1'b1;  // Reset, held at start.
  sss_pkg::sss_ctrl_wr_t pri = '0;      // Primary control write.
  sss_pkg::sss_ctrl_wr_t sec = '0;      // Secondary control write.
  logic                  fwh = 1'b0;    // Firmware hibernate level.
  logic [3:0]            wen = 4'h0;    // Wake enables.
  logic                  go = 1'b0;     // Wake order to the model.
  logic [1:0]            gdev = 2'h0;   // Device that wakes.
  logic [3:0]            gdel = 4'h0;   // Delay before its request.
  logic [7:0][2:0]       res_level;
  logic [3:0][1:0]       dev_want;
  logic [3:0][7:0]       dev_need;
  logic [3:0]            wake_request;
  logic [7:0]            res_on;
  logic [3:0][1:0]       dev_state;
  sss_pkg::sss_status_t  status;
  sss_pkg::sss_state_t   sys_state;
  logic                  busy;
  logic                  wake_event;
  int                    num_errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;

  always #2 clk = ~clk;

  sss_top u_sss_top (.clk(clk), .reset(reset), .primary_pm_control(pri),
    .secondary_pm_control(sec), .firmware_assisted_hibernate(fwh), .res_level(res_level),
    .dev_want(dev_want), .dev_need(dev_need), .wake_enable(wen),
    .wake_request(wake_request), .res_on(res_on), .dev_state(dev_state), .status(status),
    .sys_state(sys_state), .busy(busy), .wake_event(wake_event));

  sss_far_side u_sss_far_side (.clk(clk), .reset(reset), .go(go), .dev(gdev), .delay(gdel),
    .wake_event(wake_event), .res_level(res_level), .dev_want(dev_want),
    .dev_need(dev_need), .wake_request(wake_request));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares one value and counts it.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // One-cycle control write on either half; ends at the negedge after the taking edge.
  task automatic ctrl(input logic sel, input logic [2:0] typ, input logic trig);
    sss_pkg::sss_ctrl_wr_t w;
    w = '0;
    w.wr = 1'b1;
    w.data[`SSS_TYPE_LSB +: `SSS_TYPE_W] = typ;
    w.data[`SSS_TRIG_BIT] = trig;
    @(negedge clk);
    if (sel)
      sec = w;
    else
      pri = w;
    @(negedge clk);
    pri = '0;
    sec = '0;
  endtask : ctrl

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset levels, then the working state after release.
  task automatic t_reset();
    check("res_on", 16'(res_on), 16'h00FF);
    check("busy", 16'(busy), 16'h0000);
    reset = 1'b0;
    @(negedge clk);
    check("status", 16'(status), 16'h003E);
    check("sys_state", 16'(sys_state), 16'h0000);
  endtask : t_reset

  // Writes without trigger, with type S0 or with an unused type do nothing.
  task automatic t_ignored();
    ctrl(1'b0, 3'h0, 1'b1);
    ctrl(1'b1, 3'h6, 1'b1);
    ctrl(1'b0, 3'h7, 1'b1);
    ctrl(1'b0, 3'h3, 1'b0);
    repeat (`SSS_SETTLE_CYC + 3) @(negedge clk);
    check("idle busy", 16'(busy), 16'h0000);
    check("idle state", 16'(sys_state), 16'h0000);
  endtask : t_ignored

  // Enters sleep state t, checks it, refuses a new trigger, then wakes.
  task automatic t_sleep(input logic sel, input logic [2:0] t, input logic h, input logic [3:0] d);
    logic [7:0] on;
    int         n;
    fwh = h;
    wen = 4'h0;
    if (sel)
      ctrl(1'b0, t, 1'b0);
    // Cache flush and memory save are software duties assumed done before this trigger.
    ctrl(sel, t, 1'b1);
    check("busy", 16'(busy), 16'h0001);
    n = 0;
    while (sys_state !== t && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    check("sys_state", 16'(sys_state), 16'(t));
    for (int i = 0; i < 8; i++)
      on[i] = (i >= t);
    check("res_on", 16'(res_on), 16'(on));
    check("dev_state", 16'(dev_state), {8'h00, 2'h3, (t <= 3'h3) ? 2'h0 : 2'h3,
      (t == 3'h1) ? 2'h2 : 2'h3, (t <= 3'h3) ? 2'h1 : 2'h3});
    // Resume flags still describe the previous wake here; they are judged after this one.
    check("status", 16'(status & 6'h38), 16'({1'b0, t == 3'h1, t <= 3'h3, 3'h0}));
    ctrl(~sel, (t == 3'h2) ? 3'h3 : 3'h2, 1'b1);
    check("refused", 16'(sys_state), 16'(t));
    go = 1'b1;
    gdev = 2'h3;
    gdel = d;
    @(negedge clk);
    go = 1'b0;
    repeat (8) @(negedge clk);
    check("no wake", 16'(sys_state), 16'(t));
    wen = 4'h8;
    n = 0;
    while (wake_event !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check("wake_event", 16'(wake_event), 16'h0001);
    check("woken", 16'(sys_state), 16'h0000);
    check("res woken", 16'(res_on), 16'h00FF);
    @(negedge clk);
    check("pulse", 16'(wake_event), 16'h0000);
    check("run", 16'(status.run), 16'h0001);
    check("resume", 16'(status & 6'h07), 16'({t != 3'h1, t == 3'h5, t == 3'h4 && !h}));
    wen = 4'h0;
  endtask : t_sleep

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(negedge clk);
    t_reset();
    t_ignored();
    t_sleep(1'b0, 3'h1, 1'b0, 4'h0);
    t_sleep(1'b1, 3'h2, 1'b0, 4'h3);
    t_sleep(1'b0, 3'h3, 1'b0, 4'h0);
    t_sleep(1'b1, 3'h4, 1'b0, 4'h2);
    t_sleep(1'b0, 3'h4, 1'b1, 4'h0);
    t_sleep(1'b1, 3'h5, 1'b0, 4'h1);
    wrap_up();
  end
endmodule : sss_top_bench
